// >>> hw/udf_flow_pins.sv
// UART core with modem flow pin and DMA request pins.
// Assumes all inputs synchronous to clk; DEPTH is a power of two.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "udf_defines.svh"
module udf_flow_pins
	import udf_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int BIT_CYCLES = 868,
	parameter int RX_TIMEOUT_CYCLES = 34720
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chipSel,
	input wire logic writeStrobe,
	input wire logic writeStrobeN,
	input wire logic regRd,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic rxSerial,
	output logic txSerial,
	output logic rtsN,
	output logic rxDmaReqN,
	output logic txDmaReqN
);
	// ***************************************************************
	// Widths
	// ***************************************************************
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int BW = $clog2(BIT_CYCLES + 1);
	localparam int TW = $clog2(RX_TIMEOUT_CYCLES + 1);

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic hostWr; // Qualified write, either strobe
	logic [7:0] modemCtrl; // modem_control_reg
	logic [7:0] fifoCtrl; // fifo_control_reg, kept bits only
	logic fifoEn; // FIFOs enabled
	logic dmaMode1; // Multi-transfer DMA selected
	logic loopback; // Internal loopback
	logic autoRts; // Automatic flow control
	logic fctlWr; // Write to FIFO control
	logic rxClr; // Flush receive FIFO
	logic txClr; // Flush transmit FIFO
	logic rxLine; // Receiver input after loopback mux
	// Receiver
	udf_ser_e rxState;
	logic [BW-1:0] rxBaud; // Bit-time down counter
	logic [2:0] rxBit; // Data bit index
	logic [7:0] rxShift; // Assembling character
	logic rxPush; // One-cycle: character done
	logic [7:0] rxMem [DEPTH]; // Receive FIFO storage
	logic [PW-1:0] rxWr;
	logic [PW-1:0] rxRd;
	logic [CW-1:0] rxCount;
	logic [CW-1:0] rxLimit; // Capacity in current mode
	logic [CW-1:0] rxTrig; // Trigger level
	logic rxFull;
	logic rxAccept;
	logic rxPop;
	logic rxAtTrig;
	logic overrun; // Sticky overrun flag
	logic [TW-1:0] rxIdleCnt; // Cycles since last FIFO activity
	logic rxTimeout;
	// Transmitter
	logic [7:0] txMem [DEPTH]; // Transmit FIFO storage
	logic [PW-1:0] txWr;
	logic [PW-1:0] txRd;
	logic [CW-1:0] txCount;
	logic [CW-1:0] txLimit;
	logic txFull;
	logic txPush;
	logic txPop;
	logic bufInReady; // Buffer can take a word
	logic bufValid; // Buffer holds a word
	logic [7:0] bufData;
	logic serReady; // Serializer can start
	udf_ser_e txState;
	logic [BW-1:0] txBaud;
	logic [2:0] txBit;
	logic [7:0] txShift;
	udf_status_s status; // Assembled status byte

	// ***************************************************************
	// Host write decode
	// ***************************************************************
	// Either polarity writes; host ties the other inactive
	assign hostWr = chipSel & (writeStrobe | ~writeStrobeN);
	assign fctlWr = hostWr && (regAddr == `UDF_OFS_FIFO);
	assign fifoEn = fifoCtrl[`UDF_FCTL_EN];
	// Legacy mode forces mode 0 for both DMA pins
	assign dmaMode1 = fifoEn & fifoCtrl[`UDF_FCTL_DMA];
	assign loopback = modemCtrl[`UDF_MCTL_LOOP];
	// Both bits set, and only in FIFO mode
	assign autoRts = modemCtrl[`UDF_MCTL_AUTO] & modemCtrl[`UDF_MCTL_RTS]
		& fifoEn;
	// Toggling the enable flushes both FIFOs to avoid stale mixes
	assign rxClr = fctlWr && (regWrData[`UDF_FCTL_RXCLR]
		|| (regWrData[`UDF_FCTL_EN] != fifoEn));
	assign txClr = fctlWr && (regWrData[`UDF_FCTL_TXCLR]
		|| (regWrData[`UDF_FCTL_EN] != fifoEn));

	// Modem control register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			modemCtrl <= `UDF_MCTL_RST;
		end
		else if (hostWr && (regAddr == `UDF_OFS_MODEM))
		begin
			modemCtrl <= regWrData;
		end
	end

	// FIFO control register; flush bits self-clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fifoCtrl <= `UDF_FCTL_RST;
		end
		else if (fctlWr)
		begin
			fifoCtrl <= regWrData & `UDF_FCTL_KEEP;
		end
	end

	// ***************************************************************
	// Receiver
	// ***************************************************************
	// Loopback feeds our own line back in
	assign rxLine = loopback ? txSerial : rxSerial;

	// Deserializer: 8N1, samples mid-bit
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rxState <= SER_IDLE;
			rxBaud <= '0;
			rxBit <= `UDF_FIRST_BIT;
			rxShift <= `UDF_ZERO_BYTE;
			rxPush <= 1'b0;
		end
		else
		begin
			rxPush <= 1'b0;
			unique case (rxState)
				SER_IDLE:
				begin
					// Falling edge starts a frame
					if (!rxLine)
					begin
						rxState <= SER_START;
						rxBaud <= BW'(BIT_CYCLES / 2);
					end
				end
				SER_START:
				begin
					if (rxBaud != '0)
						rxBaud <= rxBaud - 1'b1;
					else if (rxLine)
						rxState <= SER_IDLE; // Glitch, not a start bit
					else
					begin
						rxState <= SER_DATA;
						rxBaud <= BW'(BIT_CYCLES - 1);
						rxBit <= `UDF_FIRST_BIT;
					end
				end
				SER_DATA:
				begin
					if (rxBaud != '0)
						rxBaud <= rxBaud - 1'b1;
					else
					begin
						rxShift <= {rxLine, rxShift[7:1]};
						rxBaud <= BW'(BIT_CYCLES - 1);
						if (rxBit == `UDF_LAST_BIT)
							rxState <= SER_STOP;
						else
							rxBit <= rxBit + 1'b1;
					end
				end
				SER_STOP:
				begin
					if (rxBaud != '0)
						rxBaud <= rxBaud - 1'b1;
					else
					begin
						// Framing errors are dropped silently
						rxState <= SER_IDLE;
						rxPush <= rxLine;
					end
				end
			endcase
		end
	end

	// Legacy mode behaves as a one-character holding register
	assign rxLimit = fifoEn ? CW'(DEPTH) : CW'(1);
	assign rxFull = (rxCount >= rxLimit);
	assign rxAccept = rxPush & ~rxFull;
	assign rxPop = regRd && (regAddr == `UDF_OFS_DATA) && (rxCount != '0);

	// Trigger level from the two top control bits
	always_comb
	begin
		unique case (fifoCtrl[`UDF_FCTL_TRIG_HI:`UDF_FCTL_TRIG_LO])
			2'h0: rxTrig = CW'(`UDF_TRIG_SEL0);
			2'h1: rxTrig = CW'(`UDF_TRIG_SEL1);
			2'h2: rxTrig = CW'(`UDF_TRIG_SEL2);
			2'h3: rxTrig = CW'(`UDF_TRIG_SEL3);
		endcase
	end
	assign rxAtTrig = (rxCount >= rxTrig);

	// Receive storage
	always_ff @(posedge clk)
	begin
		if (rxAccept)
		begin
			rxMem[rxWr] <= rxShift;
		end
	end

	// Receive pointers; flush and push may meet, flush wins
	always_ff @(posedge clk)
	begin
		if (sys_rst || rxClr)
		begin
			rxWr <= '0;
			rxRd <= '0;
			rxCount <= '0;
		end
		else
		begin
			rxWr <= rxWr + PW'(rxAccept);
			rxRd <= rxRd + PW'(rxPop);
			rxCount <= rxCount + CW'(rxAccept) - CW'(rxPop);
		end
	end

	// Overrun: a lost word in the clearing read still sets it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			overrun <= 1'b0;
		else if (rxPush && rxFull)
			overrun <= 1'b1;
		else if (regRd && (regAddr == `UDF_OFS_STATUS))
			overrun <= 1'b0;
	end

	// Timeout: characters waiting with no FIFO traffic
	always_ff @(posedge clk)
	begin
		if (sys_rst || rxAccept || rxPop || (rxCount == '0))
		begin
			rxIdleCnt <= '0;
			rxTimeout <= 1'b0;
		end
		else if (rxIdleCnt == TW'(RX_TIMEOUT_CYCLES))
			rxTimeout <= 1'b1;
		else
			rxIdleCnt <= rxIdleCnt + 1'b1;
	end

	// ***************************************************************
	// Flow control pin
	// ***************************************************************
	// Low tells the modem we can take data; hysteresis in auto mode
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rtsN <= 1'b1;
		else if (loopback || !modemCtrl[`UDF_MCTL_RTS])
			rtsN <= 1'b1;
		else if (autoRts)
		begin
			// Threshold logic, not software, drops it
			if (rxAtTrig)
				rtsN <= 1'b1;
			else if (rxCount == '0)
				rtsN <= 1'b0;
		end
		else
			rtsN <= 1'b0;
	end

	// ***************************************************************
	// DMA request pins
	// ***************************************************************
	// Receive request: level in mode 0, burst window in mode 1
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rxDmaReqN <= 1'b1;
		else if (dmaMode1)
		begin
			// Stays low so the controller drains back to back
			if (rxAtTrig || rxTimeout)
				rxDmaReqN <= 1'b0;
			else if (rxCount == '0)
				rxDmaReqN <= 1'b1;
		end
		else
			rxDmaReqN <= (rxCount == '0);
	end

	// Transmit request: empty asks; full or written stops it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			txDmaReqN <= 1'b1;
		else if (dmaMode1)
		begin
			if (txCount == '0)
				txDmaReqN <= 1'b0;
			else if (txFull)
				txDmaReqN <= 1'b1;
		end
		else
			txDmaReqN <= (txCount != '0);
	end

	// ***************************************************************
	// Transmit FIFO
	// ***************************************************************
	// Writes to a full FIFO are dropped
	assign txLimit = fifoEn ? CW'(DEPTH) : CW'(1);
	assign txFull = (txCount >= txLimit);
	assign txPush = hostWr && (regAddr == `UDF_OFS_DATA) && !txFull;
	assign txPop = (txCount != '0) && bufInReady;

	// Transmit storage
	always_ff @(posedge clk)
	begin
		if (txPush)
		begin
			txMem[txWr] <= regWrData;
		end
	end

	// Transmit pointers
	always_ff @(posedge clk)
	begin
		if (sys_rst || txClr)
		begin
			txWr <= '0;
			txRd <= '0;
			txCount <= '0;
		end
		else
		begin
			txWr <= txWr + PW'(txPush);
			txRd <= txRd + PW'(txPop);
			txCount <= txCount + CW'(txPush) - CW'(txPop);
		end
	end

	// Two-entry buffer decouples FIFO from a stalling serializer
	udf_skid_buf #(
		.W(8),
		.DEPTH(2)
	) u_txBuf (
		.clk(clk),
		.sys_rst(sys_rst),
		.inValid(txCount != '0),
		.inReady(bufInReady),
		.inData(txMem[txRd]),
		.outValid(bufValid),
		.outReady(serReady),
		.outData(bufData)
	);

	// ***************************************************************
	// Serializer
	// ***************************************************************
	assign serReady = (txState == SER_IDLE);

	// 8N1 shifter; line idles at mark
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			txState <= SER_IDLE;
			txBaud <= '0;
			txBit <= `UDF_FIRST_BIT;
			txShift <= `UDF_ZERO_BYTE;
			txSerial <= 1'b1;
		end
		else
		begin
			unique case (txState)
				SER_IDLE:
				begin
					txSerial <= 1'b1;
					if (bufValid)
					begin
						txShift <= bufData;
						txSerial <= 1'b0;
						txBaud <= BW'(BIT_CYCLES - 1);
						txState <= SER_START;
					end
				end
				SER_START:
				begin
					if (txBaud != '0)
						txBaud <= txBaud - 1'b1;
					else
					begin
						txSerial <= txShift[0];
						txShift <= {1'b0, txShift[7:1]};
						txBit <= `UDF_FIRST_BIT;
						txBaud <= BW'(BIT_CYCLES - 1);
						txState <= SER_DATA;
					end
				end
				SER_DATA:
				begin
					if (txBaud != '0)
						txBaud <= txBaud - 1'b1;
					else
					begin
						txBaud <= BW'(BIT_CYCLES - 1);
						if (txBit == `UDF_LAST_BIT)
						begin
							txSerial <= 1'b1;
							txState <= SER_STOP;
						end
						else
						begin
							txSerial <= txShift[0];
							txShift <= {1'b0, txShift[7:1]};
							txBit <= txBit + 1'b1;
						end
					end
				end
				SER_STOP:
				begin
					if (txBaud != '0)
						txBaud <= txBaud - 1'b1;
					else
						txState <= SER_IDLE;
				end
			endcase
		end
	end

	// ***************************************************************
	// Read port
	// ***************************************************************
	always_comb
	begin
		status = '0;
		status.txIdle = serReady && !bufValid && (txCount == '0);
		status.txEmpty = (txCount == '0);
		status.rxTimeout = rxTimeout;
		status.overrun = overrun;
		status.dataReady = (rxCount != '0);
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst || !regRd)
			regRdData <= `UDF_ZERO_BYTE;
		else
		begin
			unique case (regAddr)
				`UDF_OFS_DATA:
					regRdData <= rxPop ? rxMem[rxRd] : `UDF_ZERO_BYTE;
				`UDF_OFS_FIFO: regRdData <= fifoCtrl;
				`UDF_OFS_MODEM: regRdData <= modemCtrl;
				`UDF_OFS_STATUS: regRdData <= status;
				default: regRdData <= `UDF_ZERO_BYTE;
			endcase
		end
	end

endmodule : udf_flow_pins

// >>> hw/udf_skid_buf.sv
// Small valid/ready buffer between transmit FIFO and serializer.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/100ps
module udf_skid_buf
	import udf_pkg::*;
#(
	parameter int W = 8,
	parameter int DEPTH = 2
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem [DEPTH]; // Entry storage
	logic [PW-1:0] wrPtr; // Next slot to fill
	logic [PW-1:0] rdPtr; // Oldest slot
	logic [CW-1:0] count; // Entries held
	logic push;
	logic pop;

	// Honest flags straight from the count
	assign inReady = (count != CW'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// ***************************************************************
	// Storage
	// ***************************************************************
	// Data needs no reset; valid gates it
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			wrPtr <= wrPtr + PW'(push);
			rdPtr <= rdPtr + PW'(pop);
			count <= count + CW'(push) - CW'(pop);
		end
	end

endmodule : udf_skid_buf

// >>> pkg/udf_defines.svh
// Named constants for the UART flow-pin block: offsets, fields, resets.
// Assumes the including file sits in one compile unit with udf_pkg.
`ifndef UDF_DEFINES_SVH
`define UDF_DEFINES_SVH

// ***********************************************************************
// Register offsets of the 3-bit address port
// ***********************************************************************
`define UDF_OFS_DATA 3'h0
`define UDF_OFS_FIFO 3'h2
`define UDF_OFS_MODEM 3'h4
`define UDF_OFS_STATUS 3'h5

// ***********************************************************************
// Field positions
// ***********************************************************************
`define UDF_FCTL_EN 0
`define UDF_FCTL_RXCLR 1
`define UDF_FCTL_TXCLR 2
`define UDF_FCTL_DMA 3
`define UDF_FCTL_TRIG_LO 6
`define UDF_FCTL_TRIG_HI 7
`define UDF_MCTL_RTS 1
`define UDF_MCTL_LOOP 4
`define UDF_MCTL_AUTO 5

// ***********************************************************************
// Reset values and masks
// ***********************************************************************
`define UDF_FCTL_RST 8'h00
`define UDF_MCTL_RST 8'h00
`define UDF_FCTL_KEEP 8'hC9
`define UDF_ZERO_BYTE 8'h00

// ***********************************************************************
// Receive trigger levels in characters
// ***********************************************************************
`define UDF_TRIG_SEL0 8'h01
`define UDF_TRIG_SEL1 8'h10
`define UDF_TRIG_SEL2 8'h20
`define UDF_TRIG_SEL3 8'h38

// ***********************************************************************
// Serial framing
// ***********************************************************************
`define UDF_LAST_BIT 3'h7
`define UDF_FIRST_BIT 3'h0

`endif

// >>> pkg/udf_pkg.sv
// Types shared by the UART flow-pin block.
// Assumes nothing beyond a SystemVerilog compiler.
package udf_pkg;

	// Serial engine states, shared by receiver and transmitter
	typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP}
		udf_ser_e;

	// Status byte as seen on a read
	typedef struct packed {
		logic rsvdHi;     // Reads zero
		logic txIdle;     // Serializer idle and nothing queued
		logic txEmpty;    // Transmit FIFO empty
		logic [1:0] rsvd; // Reads zero
		logic rxTimeout;  // Receive timeout reached
		logic overrun;    // Sticky: word lost to a full FIFO
		logic dataReady;  // At least one received character
	} udf_status_s;

endpackage : udf_pkg

// >>> test/udf_flow_pins_chk.sv
// Checker for the UART flow-pin block: pin levels against writes.
// Assumes it is bound to udf_flow_pins and sees its ports only.
`timescale 1ns/100ps
`include "udf_defines.svh"
module udf_flow_pins_chk
	import udf_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chipSel,
	input wire logic writeStrobe,
	input wire logic writeStrobeN,
	input wire logic regRd,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic rxSerial,
	input wire logic txSerial,
	input wire logic rtsN,
	input wire logic rxDmaReqN,
	input wire logic txDmaReqN
);
	// ***************************************************************
	// Helper decode
	// ***************************************************************
	// Write taken by either strobe polarity while selected
	wire logic wrTaken;
	wire logic wrModem;
	assign wrTaken = chipSel & (writeStrobe | ~writeStrobeN);
	assign wrModem = wrTaken && (regAddr == `UDF_OFS_MODEM);

	// ***************************************************************
	// Reset levels: checked through reset, so no disable here
	// ***************************************************************
	property p_rtsRst;
		@(posedge clk) sys_rst |=> rtsN;
	endproperty
	a_rtsRst: assert property (p_rtsRst)
		else $error("rts not inactive after reset");
	property p_txRst;
		@(posedge clk) sys_rst |=> txSerial;
	endproperty
	a_txRst: assert property (p_txRst)
		else $error("serial output not marking after reset");
	property p_rxRst;
		@(posedge clk) sys_rst |=> rxDmaReqN;
	endproperty
	a_rxRst: assert property (p_rxRst)
		else $error("receive request active after reset");
	property p_txReqRst;
		@(posedge clk) sys_rst |=> txDmaReqN;
	endproperty
	a_txReqRst: assert property (p_txReqRst)
		else $error("transmit request active in reset");

	// ***************************************************************
	// Running behaviour
	// ***************************************************************
	// Read data only in the cycle after a read strobe
	property p_rdIdle;
		@(posedge clk) disable iff (sys_rst)
		!regRd |=> regRdData == `UDF_ZERO_BYTE;
	endproperty
	a_rdIdle: assert property (p_rdIdle)
		else $error("read data outside its cycle");
	// Cleared request bit forces inactive, auto mode or not
	property p_rtsOff;
		@(posedge clk) disable iff (sys_rst)
		wrModem && !regWrData[`UDF_MCTL_RTS] |=> ##1 rtsN;
	endproperty
	a_rtsOff: assert property (p_rtsOff)
		else $error("rts active with request bit clear");
	property p_rtsLoop;
		@(posedge clk) disable iff (sys_rst)
		wrModem && regWrData[`UDF_MCTL_LOOP] |=> ##1 rtsN;
	endproperty
	a_rtsLoop: assert property (p_rtsLoop)
		else $error("rts active in loopback");
	// Plain manual mode: bit set drives active
	property p_rtsOn;
		@(posedge clk) disable iff (sys_rst)
		wrModem && regWrData[`UDF_MCTL_RTS] && !regWrData[`UDF_MCTL_LOOP]
			&& !regWrData[`UDF_MCTL_AUTO] |=> ##1 !rtsN;
	endproperty
	a_rtsOn: assert property (p_rtsOn)
		else $error("rts inactive with request bit set");
endmodule : udf_flow_pins_chk

bind udf_flow_pins udf_flow_pins_chk u_chk (.clk(clk), .sys_rst(sys_rst),
	.chipSel(chipSel), .writeStrobe(writeStrobe),
	.writeStrobeN(writeStrobeN), .regRd(regRd), .regAddr(regAddr),
	.regWrData(regWrData), .regRdData(regRdData), .rxSerial(rxSerial),
	.txSerial(txSerial), .rtsN(rtsN), .rxDmaReqN(rxDmaReqN),
	.txDmaReqN(txDmaReqN));

// >>> test/udf_flow_pins_tb.sv
// Self-checking bench for the UART flow-pin block.
// Assumes the modem model and the bound checker are compiled too.
`timescale 1ns/100ps
`include "udf_defines.svh"
module udf_flow_pins_tb
	import udf_pkg::*;
;
	logic clk, sys_rst, chipSel, writeStrobe, writeStrobeN, regRd;
	logic [2:0] regAddr;
	logic [7:0] regWrData, sendByte, d;
	logic sendGo;
	wire logic [7:0] regRdData;
	wire logic rxSerial, txSerial, rtsN, rxDmaReqN, txDmaReqN, sendBusy;
	int n_mismatch, cmp_count;
	int cycles = 0;
	// Short bit time and timeout keep the run brief
	udf_flow_pins #(.DEPTH(64), .BIT_CYCLES(8), .RX_TIMEOUT_CYCLES(100))
	dut (.clk(clk), .sys_rst(sys_rst), .chipSel(chipSel),
		.writeStrobe(writeStrobe), .writeStrobeN(writeStrobeN),
		.regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .rxSerial(rxSerial), .txSerial(txSerial),
		.rtsN(rtsN), .rxDmaReqN(rxDmaReqN), .txDmaReqN(txDmaReqN));
	udf_modem_model #(.BIT_CYCLES(8)) modem (.clk(clk), .rtsN(rtsN),
		.sendGo(sendGo), .sendByte(sendByte), .rxLine(rxSerial),
		.sendBusy(sendBusy));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard well above the fewer than 1500 cycles needed
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	task complete_run();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One write; the unused strobe stays inactive throughout
	task wr(input logic [2:0] a, input logic [7:0] v, input logic lowPol,
		input logic sel);
		@(posedge clk);
		chipSel <= sel;
		regAddr <= a;
		regWrData <= v;
		if (lowPol)
			writeStrobeN <= 1'b0;
		else
			writeStrobe <= 1'b1;
		@(posedge clk);
		writeStrobe <= 1'b0;
		writeStrobeN <= 1'b1;
		chipSel <= 1'b0;
	endtask : wr
	// Data taken in the one cycle after the strobe
	task rd(input logic [2:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask : rd
	function logic pinOf(input int i);
		return (i == 0) ? rtsN : (i == 1) ? rxDmaReqN : txDmaReqN;
	endfunction : pinOf
	// Bounded wait for a pin level, then judge it
	task waitPin(input string nm, input int i, input logic v, input int lim);
		int k;
		k = 0;
		while (pinOf(i) !== v && k < lim)
		begin
			@(posedge clk);
			#1 k++;
		end
		chk(nm, {7'h00, v}, {7'h00, pinOf(i)});
	endtask : waitPin
	task sendChar(input logic [7:0] b);
		int k;
		k = 0;
		@(posedge clk);
		sendByte <= b;
		sendGo <= 1'b1;
		@(posedge clk);
		sendGo <= 1'b0;
		#1 while (sendBusy && k < 300)
		begin
			@(posedge clk);
			#1 k++;
		end
	endtask : sendChar
	// Manual request-to-send, both strobes, deselected write, readback
	task t_rts();
		wr(`UDF_OFS_MODEM, 8'h02, 1'b0, 1'b1);
		waitPin("rtsN", 0, 1'b0, 4);
		wr(`UDF_OFS_MODEM, 8'h12, 1'b1, 1'b1);
		waitPin("rtsN", 0, 1'b1, 4);
		wr(`UDF_OFS_MODEM, 8'h02, 1'b1, 1'b1);
		wr(`UDF_OFS_MODEM, 8'h00, 1'b0, 1'b0);
		waitPin("rtsN", 0, 1'b0, 4);
		rd(`UDF_OFS_MODEM);
		chk("modem reg", 8'h02, d);
		rd(3'h7);
		chk("unmapped", 8'h00, d);
	endtask : t_rts
	// One character: early request in mode 0, timeout wait in mode 1
	task t_rxMode(input logic [7:0] fifo_control_reg, input logic early);
		wr(`UDF_OFS_FIFO, fifo_control_reg, 1'b0, 1'b1);
		sendChar(8'hA5);
		repeat (20) @(posedge clk);
		#1 chk("rxDmaReqN", {7'h00, !early}, {7'h00, rxDmaReqN});
		waitPin("rxDmaReqN", 1, 1'b0, 150);
		rd(`UDF_OFS_DATA);
		chk("rx data", 8'hA5, d);
		waitPin("rxDmaReqN", 1, 1'b1, 3);
	endtask : t_rxMode
	// Mode 1 burst: request stays active until the FIFO is empty
	task t_rxBurst();
		wr(`UDF_OFS_FIFO, 8'h09, 1'b0, 1'b1);
		sendChar(8'h3C);
		sendChar(8'hC3);
		repeat (20) @(posedge clk);
		rd(`UDF_OFS_DATA);
		chk("rx data", 8'h3C, d);
		chk("rxDmaReqN", 8'h00, {7'h00, rxDmaReqN});
		rd(`UDF_OFS_DATA);
		chk("rx data", 8'hC3, d);
		waitPin("rxDmaReqN", 1, 1'b1, 3);
	endtask : t_rxBurst
	// Automatic mode: threshold raises request-to-send, drain lowers it
	task t_auto();
		wr(`UDF_OFS_FIFO, 8'h01, 1'b0, 1'b1);
		wr(`UDF_OFS_MODEM, 8'h22, 1'b0, 1'b1);
		sendChar(8'h5A);
		waitPin("rtsN", 0, 1'b1, 40);
		rd(`UDF_OFS_DATA);
		chk("rx data", 8'h5A, d);
		waitPin("rtsN", 0, 1'b0, 4);
		wr(`UDF_OFS_MODEM, 8'h20, 1'b0, 1'b1);
		waitPin("rtsN", 0, 1'b1, 4);
	endtask : t_auto
	// Loopback, FIFOs off: one-character holder, second overruns
	task t_loop();
		wr(`UDF_OFS_FIFO, 8'h00, 1'b0, 1'b1);
		wr(`UDF_OFS_MODEM, 8'h10, 1'b0, 1'b1);
		wr(`UDF_OFS_DATA, 8'h11, 1'b0, 1'b1);
		wr(`UDF_OFS_DATA, 8'h22, 1'b1, 1'b1);
		// Both frames, then the receive timeout, are long done
		repeat (300) @(posedge clk);
		rd(`UDF_OFS_STATUS);
		chk("status", 8'h67, d);
		rd(`UDF_OFS_DATA);
		chk("rx data", 8'h11, d);
		rd(`UDF_OFS_STATUS);
		chk("status", 8'h60, d);
		wr(`UDF_OFS_MODEM, 8'h00, 1'b0, 1'b1);
	endtask : t_loop
	// Mode 0 transmit: request inactive while a character waits
	task t_tx0();
		wr(`UDF_OFS_FIFO, 8'h08, 1'b0, 1'b1);
		repeat (5) wr(`UDF_OFS_DATA, 8'h81, 1'b0, 1'b1);
		waitPin("txDmaReqN", 2, 1'b1, 3);
		waitPin("txDmaReqN", 2, 1'b0, 600);
	endtask : t_tx0
	// Mode 1 transmit: active when empty, inactive only when full
	task t_tx1();
		wr(`UDF_OFS_FIFO, 8'h09, 1'b0, 1'b1);
		waitPin("txDmaReqN", 2, 1'b0, 4);
		repeat (70) wr(`UDF_OFS_DATA, 8'h42, 1'b1, 1'b1);
		waitPin("txDmaReqN", 2, 1'b1, 3);
		wr(`UDF_OFS_FIFO, 8'h0D, 1'b0, 1'b1);
		waitPin("txDmaReqN", 2, 1'b0, 4);
		rd(`UDF_OFS_FIFO);
		chk("fifo reg", 8'h09, d);
	endtask : t_tx1
	initial
	begin
		sys_rst = 1'b1;
		chipSel = 1'b0;
		writeStrobe = 1'b0;
		writeStrobeN = 1'b1;
		regRd = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		sendGo = 1'b0;
		sendByte = 8'h00;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1 chk("rtsN", 8'h01, {7'h00, rtsN});
		chk("txSerial", 8'h01, {7'h00, txSerial});
		chk("rxDmaReqN", 8'h01, {7'h00, rxDmaReqN});
		waitPin("txDmaReqN", 2, 1'b0, 4);
		t_rts();
		t_rxMode(8'h48, 1'b1);
		t_rxMode(8'h41, 1'b1);
		t_rxMode(8'h49, 1'b0);
		t_rxBurst();
		t_auto();
		t_loop();
		t_tx0();
		t_tx1();
		complete_run();
	end
endmodule : udf_flow_pins_tb

// >>> test/udf_modem_model.sv
// Behavioural modem: sends 8N1 characters into the receiver.
// Assumes the bench pulses sendGo for one cycle per character.
`timescale 1ns/100ps
module udf_modem_model
	import udf_pkg::*;
#(
	parameter int BIT_CYCLES = 8
)
(
	input wire logic clk,
	input wire logic rtsN,
	input wire logic sendGo,
	input wire logic [7:0] sendByte,
	output logic rxLine,
	output logic sendBusy
);
	logic [9:0] frame; // Stop, data, start
	// Line idles at mark; only starts while request-to-send is active
	initial
	begin
		rxLine = 1'b1;
		sendBusy = 1'b0;
		forever
		begin
			@(posedge clk);
			if (sendGo)
			begin
				sendBusy <= 1'b1;
				frame = {1'b1, sendByte, 1'b0};
				while (rtsN) @(posedge clk);
				for (int i = 0; i < 10; i++)
				begin
					rxLine <= frame[i];
					repeat (BIT_CYCLES) @(posedge clk);
				end
				sendBusy <= 1'b0;
			end
		end
	end
endmodule : udf_modem_model
